// [hdl/pheie_edge_enables.sv]
// edge-selective interrupt enables for the phy session and line monitors
// Functional notes
// - address 0x0E sets rise enables where written one; reads return rise enables.
// - address 0x0F clears rise enables where written one; reads return rise enables.
// - address 0x10 holds read-write fall enables, bits four down to zero.
// - events raised only for transitions whose matching edge enable is set.
// - all rise and fall enable bits reset to one.
// - id ground events masked while pullup off and 50 ms after enabling.
// - host disconnect events only when both data pulldowns are on.
// - session valid event comes from the a-device session comparator.
// - address 0x0D holds the read-write rise enable register.
module pheie_edge_enables
    import pheie_pkg::*;
#(
    parameter int SETTLE_CYCLES = ID_SETTLE_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire pheie_reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_hit_out,
    input wire logic id_pin_grounded_in,
    input wire logic session_ended_in,
    input wire logic a_device_session_ok_in,
    input wire logic bus_voltage_ok_in,
    input wire logic host_disconnect_in,
    input wire logic id_pin_pullup_on_in,
    input wire logic dplus_pulldown_on_in,
    input wire logic dminus_pulldown_on_in,
    output logic [4:0] rise_event_out,
    output logic [4:0] fall_event_out,
    output logic [4:0] rise_enable_out,
    output logic [4:0] fall_enable_out
);
    // ==========================================
    // registers
    logic [4:0] rise_enable_reg;
    logic [4:0] fall_enable_reg;
    logic [7:0] rdata_reg;
    logic hit_reg;
    logic [4:0] wbits;
    // only the five enable bits are kept; bits 7..5 drop here
    assign wbits = reg_req_in.wdata[4:0];

    // ==========================================
    // helpers
    // next rise enables after a write; other addresses leave them alone
    function automatic logic [4:0] rise_after_write(input logic [5:0] addr,
        input logic [4:0] cur, input logic [4:0] bits);
        case (addr)
            RISE_ENABLE_ADDR: rise_after_write = bits;
            RISE_ENABLE_SET_ADDR: rise_after_write = cur | bits;
            RISE_ENABLE_CLEAR_ADDR: rise_after_write = cur & ~bits;
            default: rise_after_write = cur;
        endcase
    endfunction : rise_after_write

    function automatic logic [7:0] pad_enables(input logic [4:0] bits);
        pad_enables = {3'h0, bits};
    endfunction : pad_enables

    // up picks low-to-high, otherwise high-to-low
    function automatic logic [4:0] edge_mask(input logic [4:0] now_bits,
        input logic [4:0] prev_bits, input logic up);
        if (up) begin
            edge_mask = now_bits & ~prev_bits;
        end else begin
            edge_mask = ~now_bits & prev_bits;
        end
    endfunction : edge_mask

    // host mode means both data line pulldowns on
    function automatic logic host_mode(input logic dp_on, input logic dm_on);
        host_mode = dp_on && dm_on;
    endfunction : host_mode

    // id edges pass only once the pullup has stood for the whole window
    function automatic logic id_window_done(input logic pullup_now, input logic pullup_before,
        input logic [31:0] count);
        id_window_done = pullup_now && pullup_before && count == 32'h0;
    endfunction : id_window_done

    // ==========================================
    // rise register and both aliases
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rise_enable_reg <= ENABLE_RESET;
        end else if (clk_en_in && reg_req_in.write) begin
            rise_enable_reg <= rise_after_write(reg_req_in.addr, rise_enable_reg, wbits);
        end
    end

    logic [4:0] fall_enable_next;
    always_comb begin
        fall_enable_next = fall_enable_reg;
        if (reg_req_in.write && reg_req_in.addr == FALL_EDGE_ENABLE_ADDR) begin
            fall_enable_next = wbits;
        end
    end

    // clock enable gates the load, so a frozen cycle drops the write
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            fall_enable_reg <= ENABLE_RESET;
        end else if (clk_en_in) begin
            fall_enable_reg <= fall_enable_next;
        end
    end

    // ==========================================
    // read path, registered one cycle after request
    // a read in the cycle of a write returns the old value
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_reg <= 8'h00;
            hit_reg <= 1'b0;
        end else if (clk_en_in) begin
            hit_reg <= 1'b0;
            rdata_reg <= 8'h00;
            if (reg_req_in.read) begin
                case (reg_req_in.addr)
                    RISE_ENABLE_ADDR, RISE_ENABLE_SET_ADDR, RISE_ENABLE_CLEAR_ADDR: begin
                        rdata_reg <= pad_enables(rise_enable_reg);
                        hit_reg <= 1'b1;
                    end
                    // hit marks the four mapped addresses only
                    FALL_EDGE_ENABLE_ADDR: begin
                        rdata_reg <= pad_enables(fall_enable_reg);
                        hit_reg <= 1'b1;
                    end
                    default: begin
                        rdata_reg <= 8'h00;
                        hit_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // outputs
    assign reg_rdata_out = rdata_reg;
    assign reg_hit_out = hit_reg;
    assign rise_enable_out = rise_enable_reg;
    assign fall_enable_out = fall_enable_reg;

    // ==========================================
    // id settle timer after pullup turns on
    logic [31:0] settle_count_reg;
    logic [31:0] settle_count_next;
    logic pullup_prev_reg;
    logic id_settled;
    // 32 bits hold the window count at any sensible clock rate
    always_comb begin
        settle_count_next = settle_count_reg;
        if (!id_pin_pullup_on_in) begin
            settle_count_next = 32'h0;
        end else if (!pullup_prev_reg) begin
            settle_count_next = 32'(SETTLE_CYCLES);
        end else if (settle_count_reg != 32'h0) begin
            settle_count_next = settle_count_reg - 32'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            settle_count_reg <= 32'h0;
            pullup_prev_reg <= 1'b0;
        end else if (clk_en_in) begin
            pullup_prev_reg <= id_pin_pullup_on_in;
            settle_count_reg <= settle_count_next;
        end
    end
    // dropping the pullup at any time restarts the whole window
    assign id_settled = id_window_done(id_pin_pullup_on_in, pullup_prev_reg, settle_count_reg);

    // ==========================================
    // edge detection
    pheie_monitor_t now_s;
    pheie_monitor_t prev_reg;
    // one allow bit per monitor, set unless a mask applies
    logic [4:0] allow;
    assign now_s = '{id_pin_grounded: id_pin_grounded_in, session_ended: session_ended_in,
                     session_is_valid: a_device_session_ok_in,
                     bus_voltage_ok: bus_voltage_ok_in, host_disconnect: host_disconnect_in};
    // masks ride beside the enables and never touch the registers
    always_comb begin
        allow = 5'h1F;
        allow[ID_GROUND_BIT] = id_settled;
        allow[HOST_DISC_BIT] = host_mode(dplus_pulldown_on_in, dminus_pulldown_on_in);
    end

    // prev resets low, so a level already high after reset reads as a rise
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            prev_reg <= '0;
            rise_event_out <= 5'h00;
            fall_event_out <= 5'h00;
        end else if (clk_en_in) begin
            prev_reg <= now_s;
            rise_event_out <= edge_mask(now_s, prev_reg, 1'b1) & rise_enable_reg & allow;
            fall_event_out <= edge_mask(now_s, prev_reg, 1'b0) & fall_enable_reg & allow;
        end
    end
endmodule : pheie_edge_enables

// [include/pheie_pkg.sv]
// package for the phy edge interrupt enable block
package pheie_pkg;
    // ==========================================
    // register map
    localparam logic [5:0] RISE_ENABLE_ADDR = 6'h0D;
    localparam logic [5:0] RISE_ENABLE_SET_ADDR = 6'h0E;
    localparam logic [5:0] RISE_ENABLE_CLEAR_ADDR = 6'h0F;
    localparam logic [5:0] FALL_EDGE_ENABLE_ADDR = 6'h10;
    localparam int ENABLE_BITS = 5;
    localparam logic [4:0] ENABLE_RESET = 5'h1F;
    // ==========================================
    // field positions
    localparam int HOST_DISC_BIT = 0;
    localparam int BUS_VOLTAGE_OK_BIT = 1;
    localparam int SESSION_VALID_BIT = 2;
    localparam int SESSION_ENDED_BIT = 3;
    localparam int ID_GROUND_BIT = 4;
    // ==========================================
    // timing
    localparam int CLOCK_HZ = 10_000_000;
    localparam int ID_SETTLE_MS = 50;
    localparam int ID_SETTLE_CYCLES = (CLOCK_HZ / 1000) * ID_SETTLE_MS;

    typedef struct packed {
        logic id_pin_grounded;
        logic session_ended;
        logic session_is_valid;
        logic bus_voltage_ok;
        logic host_disconnect;
    } pheie_monitor_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [5:0] addr;
        logic [7:0] wdata;
    } pheie_reg_req_t;
endpackage : pheie_pkg

// [test/pheie_edge_enables_sva.sv]
// assertions on the edge enable block ports
module pheie_edge_enables_sva
    import pheie_pkg::*;
#(parameter int SETTLE_CYCLES = ID_SETTLE_CYCLES) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire pheie_reg_req_t reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_hit_out,
    input wire logic id_pin_pullup_on_in,
    input wire logic dplus_pulldown_on_in,
    input wire logic dminus_pulldown_on_in,
    input wire logic [4:0] rise_event_out,
    input wire logic [4:0] fall_event_out,
    input wire logic [4:0] rise_enable_out,
    input wire logic [4:0] fall_enable_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // port relations
    wire logic wr = clk_en_in && reg_req_in.write;
    wire logic rd = clk_en_in && reg_req_in.read;
    wire logic [4:0] wd = reg_req_in.wdata[4:0];
    wire logic [5:0] ad = reg_req_in.addr;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    set_alias_a: assert property (wr && ad == 6'h0E |=>
        rise_enable_out == ($past(rise_enable_out) | $past(wd))) else $error("set alias");
    clear_alias_a: assert property (wr && ad == 6'h0F |=>
        rise_enable_out == ($past(rise_enable_out) & ~$past(wd))) else $error("clear alias");
    fall_write_a: assert property (wr && ad == 6'h10 |=>
        fall_enable_out == $past(wd)) else $error("fall write");
    rise_readback_a: assert property (rd && ad == 6'h0E |=>
        reg_hit_out && reg_rdata_out == {3'h0, $past(rise_enable_out)}) else $error("readback");
    event_gate_a: assert property ($stable(rise_enable_out) && $stable(fall_enable_out) |->
        (rise_event_out & ~rise_enable_out) == 5'h00 && (fall_event_out & ~fall_enable_out) == 5'h00)
        else $error("event gate");
    host_mode_a: assert property (rise_event_out[0] || fall_event_out[0] |->
        $past(dplus_pulldown_on_in) && $past(dminus_pulldown_on_in)) else $error("host mode");
    id_mask_a: assert property (!id_pin_pullup_on_in |=>
        !rise_event_out[4] && !fall_event_out[4]) else $error("id mask");
    reset_value_a: assert property ($rose(reset_n_in) |->
        rise_enable_out == 5'h1F && fall_enable_out == 5'h1F) else $error("reset value");
    cover property (rise_event_out[4]);
    cover property (fall_event_out[2]);
    cover property (reg_hit_out);
endmodule : pheie_edge_enables_sva

bind pheie_edge_enables pheie_edge_enables_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk (.*);

// [test/pheie_link_model.sv]
// link controller model issuing register requests
module pheie_link_model
    import pheie_pkg::*;
(
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    input wire logic hit_in,
    output pheie_reg_req_t req_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // access
    initial req_out = '0;
    // one-cycle request; answer taken a cycle later, so calls never overlap
    task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
        output logic [8:0] ans);
        @(negedge clk_in);
        req_out = {w, ~w, a, d};
        @(negedge clk_in);
        req_out = '0;
        ans = {hit_in, rdata_in};
    endtask : access
endmodule : pheie_link_model

// [test/tb_pheie_edge_enables.sv]
// bench for the edge enable block
module tb_pheie_edge_enables;
    timeunit 1ns;
    timeprecision 1ns;
    import pheie_pkg::*;
    logic clk, rst_n, en, pu, dp, dm, hit;
    logic [4:0] mon, re, fe;
    logic [7:0] rd;
    logic [8:0] ans;
    pheie_reg_req_t req;
    int fail_count, samples_checked, cyc;
    // ====
    // wiring
    pheie_edge_enables #(.SETTLE_CYCLES(20)) dut (.clk_in(clk), .reset_n_in(rst_n),
        .clk_en_in(en), .reg_req_in(req), .reg_rdata_out(rd), .reg_hit_out(hit),
        .id_pin_grounded_in(mon[4]), .session_ended_in(mon[3]), .a_device_session_ok_in(mon[2]),
        .bus_voltage_ok_in(mon[1]), .host_disconnect_in(mon[0]), .id_pin_pullup_on_in(pu),
        .dplus_pulldown_on_in(dp), .dminus_pulldown_on_in(dm), .rise_event_out(re),
        .fall_event_out(fe), .rise_enable_out(), .fall_enable_out());
    pheie_link_model link (.clk_in(clk), .rdata_in(rd), .hit_in(hit), .req_out(req));
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [8:0] x);
        link.access(w, a, d, ans);
        if (!w) check({7'h00, ans}, {7'h00, x});
    endtask : acc
    task automatic step(input logic [4:0] v, input logic [4:0] r, input logic [4:0] f);
        @(negedge clk);
        mon = v;
        @(negedge clk);
        check({6'h00, re, fe}, {6'h00, r, f});
    endtask : step
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        rst_n = 1'h0;
        en = 1'h1;
        pu = 1'h0;
        dp = 1'h0;
        dm = 1'h0;
        mon = 5'h00;
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
        acc(1'h0, 6'h0E, 8'h00, 9'h11F);
        acc(1'h0, 6'h10, 8'h00, 9'h11F);
        acc(1'h1, 6'h0F, 8'h05, 9'h000);
        acc(1'h0, 6'h0E, 8'h00, 9'h11A);
        acc(1'h1, 6'h0E, 8'hE1, 9'h000);
        acc(1'h0, 6'h0F, 8'h00, 9'h11B);
        acc(1'h1, 6'h10, 8'hE4, 9'h000);
        acc(1'h0, 6'h10, 8'h00, 9'h104);
        en = 1'h0;
        acc(1'h1, 6'h10, 8'h1F, 9'h000);
        en = 1'h1;
        acc(1'h0, 6'h10, 8'h00, 9'h104);
        acc(1'h1, 6'h0D, 8'h13, 9'h000);
        acc(1'h0, 6'h0D, 8'h00, 9'h113);
        acc(1'h0, 6'h11, 8'h00, 9'h000);
        $display("register test done");
        step(5'h1F, 5'h02, 5'h00);
        step(5'h00, 5'h00, 5'h04);
        pu = 1'h1;
        dp = 1'h1;
        dm = 1'h1;
        step(5'h01, 5'h01, 5'h00);
        step(5'h10, 5'h00, 5'h00);
        repeat (30) @(negedge clk);
        step(5'h00, 5'h00, 5'h00);
        step(5'h10, 5'h10, 5'h00);
        $display("event test done");
        end_of_test();
    end
endmodule : tb_pheie_edge_enables
